//--- logic/cis_pkg.sv
// constants shared by the channel interrupt summary block
package cis_pkg;
	localparam int         NUM_CH        = 14;
	localparam int         LO_CH         = 8;
	localparam int         HI_CH         = 6;
	localparam int         ADDR_W        = 8;
	localparam int         DATA_W        = 8;
	localparam int         CH_NIB_W      = 4;
	localparam int         SHAPE_IDX_W   = 3;
	localparam logic [7:0] OFF_SUM_LO    = 8'hea;
	localparam logic [7:0] OFF_SUM_HI    = 8'heb;
	localparam logic [7:0] OFF_MASK_LO   = 8'hf0;
	localparam logic [7:0] OFF_MASK_HI   = 8'hf1;
	localparam logic [7:0] OFF_ARB_ST_LO = 8'hf2;
	localparam logic [7:0] OFF_ARB_ST_HI = 8'hf3;
	localparam logic [7:0] OFF_ARB_SEL   = 8'hf4;
	localparam int         ARB_EN_BIT    = 0;
	localparam logic       ARB_EN_RST    = 1'b0;
	localparam logic [13:0] FLAG_RST     = 14'h0000;
	localparam logic [13:0] MASK_RST     = 14'h0000;
	localparam logic [13:0] ARB_RST      = 14'h0000;
	localparam logic [7:0] RDATA_IDLE    = 8'h00;
	localparam logic [1:0] HI_RSVD       = 2'h0;
	localparam logic [6:0] ARB_RSVD      = 7'h00;
	localparam logic [3:0] SHAPE_FIRST   = 4'h8;
	localparam logic [3:0] CH_NIB_LIMIT  = 4'he;
endpackage

//--- logic/cis_flag_if.sv
// flag events, clears, mask and interrupt between the summary modules
`timescale 1ns/1ps
`default_nettype none
interface cis_flag_if;
	logic [cis_pkg::NUM_CH-1:0] evt;
	logic [cis_pkg::NUM_CH-1:0] flags;
	logic [cis_pkg::NUM_CH-1:0] mask;
	logic                       clr_lo;
	logic                       clr_hi;
	logic                       irq;
	modport bank (input evt, input clr_lo, input clr_hi, output flags);
	modport gate (input flags, input mask, output irq);
	modport top  (output evt, output clr_lo, output clr_hi, output mask,
		input flags, input irq);
endinterface
`default_nettype wire

//--- logic/cis_flag_bank.sv
// sticky per-channel interrupt summary flags with clear on read
`timescale 1ns/1ps
`default_nettype none
module cis_flag_bank (
	input wire logic clk,
	input wire logic nrst,
	cis_flag_if.bank fif
);
	logic [cis_pkg::NUM_CH-1:0] flag_ff;
	logic [cis_pkg::NUM_CH-1:0] clr_vec;

	assign clr_vec = {{cis_pkg::HI_CH{fif.clr_hi}}, {cis_pkg::LO_CH{fif.clr_lo}}};

	genvar gi;
	generate
		for (gi = 0; gi < cis_pkg::NUM_CH; gi++) begin : g_flag
			// a new event in the clearing cycle still lands: set wins
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					flag_ff[gi] <= cis_pkg::FLAG_RST[gi]; // [RQ7]
				end else begin
					flag_ff[gi] <= fif.evt[gi] | (flag_ff[gi] & ~clr_vec[gi]); // [RQ8]
				end
			end
		end
	endgenerate

	assign fif.flags = flag_ff;
endmodule
`default_nettype wire

//--- logic/cis_irq_gate.sv
// masks the summary flags onto one level interrupt
`timescale 1ns/1ps
`default_nettype none
module cis_irq_gate (
	input wire logic clk,
	input wire logic nrst,
	cis_flag_if.gate fif
);
	logic irq_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(fif.flags & fif.mask);
		end
	end

	assign fif.irq = irq_ff;
endmodule
`default_nettype wire

//--- logic/cis_top.sv
// channel interrupt summary and global e1 arbitrary pulse control
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1: summary low byte bit n is 1 when channel n (0..7) raised an interrupt.
// RQ2: summary high byte bits 0..5 report channels 8..13 the same way.
// RQ3: summary high byte bits 7 and 6 always read as zero.
// RQ4: enable bit set with e1 selected puts every channel in arbitrary pulse mode.
// RQ5: enable bit clear keeps the standard e1 pulse; enable resets to zero.
// RQ6: arbitrary shaping uses each channel's own registers at offsets n8 to nF.
// RQ7: all summary flags are zero after hardware reset.
// RQ8: reading a summary byte clears its flags; only new activity sets them again.
module cis_top (
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic [cis_pkg::ADDR_W-1:0]         addr,
	input  wire logic [cis_pkg::DATA_W-1:0]         wdata,
	input  wire logic                               wr,
	input  wire logic                               rd,
	output logic      [cis_pkg::DATA_W-1:0]         rdata,
	input  wire logic [cis_pkg::NUM_CH-1:0]         chan_irq,
	input  wire logic [cis_pkg::NUM_CH-1:0]         chan_e1,
	output logic      [cis_pkg::NUM_CH-1:0]         chan_arb,
	output logic                                    shape_wr,
	output logic      [cis_pkg::CH_NIB_W-1:0]       shape_ch,
	output logic      [cis_pkg::SHAPE_IDX_W-1:0]    shape_idx,
	output logic      [cis_pkg::DATA_W-1:0]         shape_data,
	output logic                                    irq
);
	cis_flag_if fif ();

	logic                              arb_en_ff;
	logic [cis_pkg::NUM_CH-1:0]        mask_ff;
	logic [cis_pkg::NUM_CH-1:0]        chan_irq_d_ff;
	logic [cis_pkg::NUM_CH-1:0]        chan_arb_ff;
	logic [cis_pkg::DATA_W-1:0]        rdata_ff;
	logic [cis_pkg::DATA_W-1:0]        nxt_rdata;
	logic                              shape_wr_ff;
	logic [cis_pkg::CH_NIB_W-1:0]      shape_ch_ff;
	logic [cis_pkg::SHAPE_IDX_W-1:0]   shape_idx_ff;
	logic [cis_pkg::DATA_W-1:0]        shape_data_ff;
	logic                              rd_sum_lo;
	logic                              rd_sum_hi;
	logic                              shape_hit;

	function automatic logic reg_hit(input logic [cis_pkg::ADDR_W-1:0] a,
		input logic [cis_pkg::ADDR_W-1:0] off);
		reg_hit = (a == off);
	endfunction

	function automatic logic [cis_pkg::DATA_W-1:0] hi_byte(
		input logic [cis_pkg::NUM_CH-1:0] v);
		hi_byte = {cis_pkg::HI_RSVD, v[cis_pkg::NUM_CH-1:cis_pkg::LO_CH]};
	endfunction

	function automatic logic [cis_pkg::DATA_W-1:0] lo_byte(
		input logic [cis_pkg::NUM_CH-1:0] v);
		lo_byte = v[cis_pkg::LO_CH-1:0];
	endfunction

	// channel number sits in the upper nibble of a shaping address
	function automatic logic [cis_pkg::CH_NIB_W-1:0] chan_nib(
		input logic [cis_pkg::ADDR_W-1:0] a);
		chan_nib = a[cis_pkg::ADDR_W-1 -: cis_pkg::CH_NIB_W];
	endfunction

	// lower nibble picks the register slot inside one channel
	function automatic logic [cis_pkg::CH_NIB_W-1:0] slot_nib(
		input logic [cis_pkg::ADDR_W-1:0] a);
		slot_nib = a[cis_pkg::CH_NIB_W-1:0];
	endfunction

	// edge detect: a level held high by a channel counts once, so a read
	// really clears the flag until the channel shows fresh activity
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chan_irq_d_ff <= cis_pkg::FLAG_RST;
		end else begin
			chan_irq_d_ff <= chan_irq;
		end
	end

	assign fif.evt = chan_irq & ~chan_irq_d_ff; // [RQ8]

	assign rd_sum_lo  = rd & reg_hit(addr, cis_pkg::OFF_SUM_LO);
	assign rd_sum_hi  = rd & reg_hit(addr, cis_pkg::OFF_SUM_HI);
	assign fif.clr_lo = rd_sum_lo; // [RQ8]
	assign fif.clr_hi = rd_sum_hi; // [RQ8]
	assign fif.mask   = mask_ff;

	cis_flag_bank u_bank (
		.clk  (clk),
		.nrst (nrst),
		.fif  (fif.bank)
	);

	cis_irq_gate u_gate (
		.clk  (clk),
		.nrst (nrst),
		.fif  (fif.gate)
	);

	assign irq = fif.irq;

	// global arbitrary pulse enable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arb_en_ff <= cis_pkg::ARB_EN_RST; // [RQ5]
		end else if (wr && reg_hit(addr, cis_pkg::OFF_ARB_SEL)) begin
			arb_en_ff <= wdata[cis_pkg::ARB_EN_BIT];
		end
	end

	// interrupt mask, same layout as the two summary bytes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_ff <= cis_pkg::MASK_RST;
		end else if (wr && reg_hit(addr, cis_pkg::OFF_MASK_LO)) begin
			mask_ff[cis_pkg::LO_CH-1:0] <= wdata;
		end else if (wr && reg_hit(addr, cis_pkg::OFF_MASK_HI)) begin
			mask_ff[cis_pkg::NUM_CH-1:cis_pkg::LO_CH] <= wdata[cis_pkg::HI_CH-1:0];
		end
	end

	// per-channel pulse mode: arbitrary only where the channel runs e1
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chan_arb_ff <= cis_pkg::ARB_RST;
		end else begin
			chan_arb_ff <= {cis_pkg::NUM_CH{arb_en_ff}} & chan_e1; // [RQ4] [RQ5]
		end
	end

	assign chan_arb = chan_arb_ff;

	// writes to n8..nF are passed to channel n; the shaping registers live
	// in the channel, which consults its chan_arb bit to use them
	assign shape_hit = wr && (slot_nib(addr) >= cis_pkg::SHAPE_FIRST)
		&& (chan_nib(addr) < cis_pkg::CH_NIB_LIMIT); // [RQ6]

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shape_wr_ff <= 1'b0;
		end else begin
			shape_wr_ff <= shape_hit; // [RQ6]
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shape_ch_ff   <= '0;
			shape_idx_ff  <= '0;
			shape_data_ff <= '0;
		end else if (shape_hit) begin
			shape_ch_ff   <= chan_nib(addr);
			shape_idx_ff  <= addr[cis_pkg::SHAPE_IDX_W-1:0];
			shape_data_ff <= wdata;
		end
	end

	assign shape_wr   = shape_wr_ff;
	assign shape_ch   = shape_ch_ff;
	assign shape_idx  = shape_idx_ff;
	assign shape_data = shape_data_ff;

	// read decode; unmapped addresses answer zero
	always_comb begin
		nxt_rdata = cis_pkg::RDATA_IDLE;
		case (addr)
			cis_pkg::OFF_SUM_LO: begin
				nxt_rdata = lo_byte(fif.flags); // [RQ1]
			end
			cis_pkg::OFF_SUM_HI: begin
				nxt_rdata = hi_byte(fif.flags); // [RQ2] [RQ3]
			end
			cis_pkg::OFF_MASK_LO: begin
				nxt_rdata = lo_byte(mask_ff);
			end
			cis_pkg::OFF_MASK_HI: begin
				nxt_rdata = hi_byte(mask_ff);
			end
			cis_pkg::OFF_ARB_ST_LO: begin
				nxt_rdata = lo_byte(chan_arb_ff);
			end
			cis_pkg::OFF_ARB_ST_HI: begin
				nxt_rdata = hi_byte(chan_arb_ff);
			end
			cis_pkg::OFF_ARB_SEL: begin
				nxt_rdata = {cis_pkg::ARB_RSVD, arb_en_ff};
			end
			default: begin
				nxt_rdata = cis_pkg::RDATA_IDLE;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= cis_pkg::RDATA_IDLE;
		end else if (rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= cis_pkg::RDATA_IDLE;
		end
	end

	assign rdata = rdata_ff;

	a_low_read_data: assert property (@(posedge clk) disable iff (!nrst) // [RQ1]
		rd_sum_lo |=> rdata == $past(fif.flags[7:0]))
		else $error("low summary read does not show channels 0 to 7");

	a_high_read_data: assert property (@(posedge clk) disable iff (!nrst) // [RQ2]
		rd_sum_hi |=> rdata[5:0] == $past(fif.flags[13:8]))
		else $error("high summary read does not show channels 8 to 13");

	a_high_reserved_zero: assert property (@(posedge clk) disable iff (!nrst) // [RQ3]
		rd_sum_hi |=> rdata[7:6] == 2'h0)
		else $error("unused high summary bits read nonzero");

	a_arb_mode_all: assert property (@(posedge clk) disable iff (!nrst) // [RQ4]
		(arb_en_ff && chan_e1 == 14'h3fff) |=> chan_arb == 14'h3fff)
		else $error("enable with e1 did not place all channels in arbitrary mode");

	a_arb_off_normal: assert property (@(posedge clk) disable iff (!nrst) // [RQ5]
		!arb_en_ff |=> chan_arb == 14'h0000)
		else $error("arbitrary mode active while enable is clear");

	a_arb_en_write: assert property (@(posedge clk) disable iff (!nrst) // [RQ5]
		(wr && addr == 8'hf4) |=> arb_en_ff == $past(wdata[0]) ##1
		chan_arb == ({14{$past(arb_en_ff)}} & $past(chan_e1)))
		else $error("enable write did not reach the channel modes in two cycles");

	a_shape_forward: assert property (@(posedge clk) disable iff (!nrst) // [RQ6]
		(wr && addr[3:0] >= 4'h8 && addr[7:4] < 4'he) |=>
		shape_wr && shape_ch == $past(addr[7:4]) && shape_data == $past(wdata))
		else $error("shaping register write not forwarded to its channel");

	a_shape_ignore_global: assert property (@(posedge clk) disable iff (!nrst) // [RQ6]
		(wr && addr[7:4] >= 4'he) |=> !shape_wr)
		else $error("global register write forwarded as a shaping write");

	a_flag_read_clear: assert property (@(posedge clk) disable iff (!nrst) // [RQ8]
		rd_sum_lo |=> fif.flags[7:0] == $past(fif.evt[7:0]))
		else $error("low summary flags not cleared by read");

	a_flag_set_wins: assert property (@(posedge clk) disable iff (!nrst) // [RQ8]
		(rd_sum_hi && fif.evt[13]) |=> fif.flags[13])
		else $error("event in clearing cycle was lost");

	a_flag_no_spurious: assert property (@(posedge clk) disable iff (!nrst) // [RQ8]
		(!fif.flags[0] && !fif.evt[0]) |=> !fif.flags[0])
		else $error("flag set without new channel activity");

	a_level_sets_once: assert property (@(posedge clk) disable iff (!nrst) // [RQ8]
		(chan_irq[3] && $past(chan_irq[3]) && rd_sum_lo) |=> !fif.flags[3])
		else $error("steady channel level re-armed a cleared flag");

	a_irq_follows: assert property (@(posedge clk) disable iff (!nrst)
		(|(fif.flags & mask_ff)) |=> irq)
		else $error("interrupt output missing for unmasked flag");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
		!rd |=> rdata == 8'h00)
		else $error("read data held outside the answer cycle");

	// reset checks run without disable so that the reset state itself is watched
	a_flags_reset_zero: assert property (@(posedge clk) // [RQ7]
		!nrst |=> fif.flags == cis_pkg::FLAG_RST)
		else $error("summary flags not zero after reset");

	a_outputs_reset_idle: assert property (@(posedge clk) // [RQ5]
		!nrst |=> rdata == cis_pkg::RDATA_IDLE && chan_arb == cis_pkg::ARB_RST && !irq && !shape_wr)
		else $error("outputs not idle after reset");

	a_arb_en_reset: assert property (@(posedge clk) // [RQ5]
		!nrst |=> arb_en_ff == cis_pkg::ARB_EN_RST)
		else $error("arbitrary enable not clear after reset");

	a_rise_sets_flag: assert property (@(posedge clk) disable iff (!nrst) // [RQ1] [RQ2]
		((chan_irq & ~$past(chan_irq)) != cis_pkg::FLAG_RST) |=>
		(fif.flags & ($past(chan_irq) & ~$past(chan_irq, 2))) == ($past(chan_irq) & ~$past(chan_irq, 2)))
		else $error("channel activity did not set its summary flag");

	a_irq_masked_quiet: assert property (@(posedge clk) disable iff (!nrst)
		!(|(fif.flags & mask_ff)) |=> !irq)
		else $error("interrupt output high with no unmasked flag");

	a_mask_write_low: assert property (@(posedge clk) disable iff (!nrst)
		(wr && addr == cis_pkg::OFF_MASK_LO) |=> mask_ff[cis_pkg::LO_CH-1:0] == $past(wdata))
		else $error("low mask write not taken");

	a_mask_write_high: assert property (@(posedge clk) disable iff (!nrst)
		(wr && addr == cis_pkg::OFF_MASK_HI) |=> mask_ff[13:8] == $past(wdata[5:0]))
		else $error("high mask write not taken");

	a_shape_index_fwd: assert property (@(posedge clk) disable iff (!nrst) // [RQ6]
		(wr && addr[3:0] >= 4'h8 && addr[7:4] < 4'he) |=> shape_idx == $past(addr[2:0]))
		else $error("shaping write forwarded with wrong register index");

	a_shape_needs_write: assert property (@(posedge clk) disable iff (!nrst) // [RQ6]
		!wr |=> !shape_wr)
		else $error("shaping strobe without a write");

	a_shape_fields_hold: assert property (@(posedge clk) disable iff (!nrst) // [RQ6]
		!wr |=> $stable(shape_ch) && $stable(shape_idx) && $stable(shape_data))
		else $error("shaping fields changed without a shaping write");

	a_high_read_clear: assert property (@(posedge clk) disable iff (!nrst) // [RQ8]
		rd_sum_hi |=> fif.flags[13:8] == $past(fif.evt[13:8]))
		else $error("high summary flags not cleared by read");

	// a flag may only drop through a read of its own byte
	a_flags_keep_unread: assert property (@(posedge clk) disable iff (!nrst) // [RQ8]
		!(rd && (addr == 8'hea || addr == 8'heb)) |=>
		(fif.flags & $past(fif.flags)) == $past(fif.flags))
		else $error("summary flag dropped without a read");

	a_arb_sel_read: assert property (@(posedge clk) disable iff (!nrst) // [RQ4] [RQ5]
		(rd && addr == 8'hf4) |=> rdata == {7'h00, $past(arb_en_ff)})
		else $error("enable register read back wrong");

	a_arb_per_chan: assert property (@(posedge clk) disable iff (!nrst) // [RQ4]
		arb_en_ff |=> chan_arb == $past(chan_e1))
		else $error("arbitrary mode does not follow the e1 channels");

	a_arb_status_read: assert property (@(posedge clk) disable iff (!nrst) // [RQ4]
		(rd && addr == 8'hf2) |=> rdata == $past(chan_arb[7:0]))
		else $error("pulse mode status read back wrong");

	a_mask_read_low: assert property (@(posedge clk) disable iff (!nrst)
		(rd && addr == 8'hf0) |=> rdata == $past(mask_ff[7:0]))
		else $error("low mask read back wrong");

	a_mask_read_high: assert property (@(posedge clk) disable iff (!nrst)
		(rd && addr == 8'hf1) |=> rdata == {2'h0, $past(mask_ff[13:8])})
		else $error("high mask read back wrong");
endmodule
`default_nettype wire

//--- tb/cis_top_bench.sv
// self-checking bench for the channel interrupt summary block
`timescale 1ns/1ps
`default_nettype none
module cis_top_bench;
	logic        clk;
	logic        nrst;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [13:0] chan_irq;
	logic [13:0] chan_e1;
	logic [13:0] chan_arb;
	logic        shape_wr;
	logic [3:0]  shape_ch;
	logic [2:0]  shape_idx;
	logic [7:0]  shape_data;
	logic        irq;
	int          failures;
	int          tests_run;
	integer      seed;
	logic [7:0]  rv;
	logic [13:0] pat;
	logic [13:0] msk;
	logic [2:0]  idx;
	logic [7:0]  regs [8] = '{8'hea, 8'heb, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'h55};

	cis_top dut (
		.clk        (clk),
		.nrst       (nrst),
		.addr       (addr),
		.wdata      (wdata),
		.wr         (wr),
		.rd         (rd),
		.rdata      (rdata),
		.chan_irq   (chan_irq),
		.chan_e1    (chan_e1),
		.chan_arb   (chan_arb),
		.shape_wr   (shape_wr),
		.shape_ch   (shape_ch),
		.shape_idx  (shape_idx),
		.shape_data (shape_data),
		.irq        (irq)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// expected high summary byte: two unused top bits always zero
	function automatic logic [7:0] sum_hi(input logic [13:0] p);
		return {2'b00, p[13:8]};
	endfunction

	function automatic logic [7:0] exp_irq(input logic [13:0] p, input logic [13:0] m);
		return {7'h00, |(p & m)};
	endfunction

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// strobes are one cycle; the gap edge before the next call avoids double drives
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard: the whole run needs far fewer cycles than this
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end

	initial begin
		seed = 32'he074;
		failures = 0;
		tests_run = 0;
		nrst = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		chan_irq = 14'h0000;
		chan_e1 = 14'h0000;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		chk14(chan_arb, 14'h0000);
		foreach (regs[i]) begin
			rd_reg(regs[i], rv);
			chk8(rv, 8'h00);
		end
		cycles(1);
		chk8(rdata, 8'h00);
		for (int r = 0; r < 5; r++) begin
			pat = (r == 0) ? 14'h3fff : 14'($random(seed));
			msk = (r == 1) ? 14'h0000 : 14'($random(seed));
			wr_reg(8'hf0, msk[7:0]);
			wr_reg(8'hf1, {2'b00, msk[13:8]});
			rd_reg(8'hf1, rv);
			chk8(rv, {2'b00, msk[13:8]});
			rd_reg(8'hf0, rv);
			chk8(rv, msk[7:0]);
			@(posedge clk);
			chan_irq <= pat;
			cycles(3);
			chk8({7'h00, irq}, exp_irq(pat, msk));
			rd_reg(8'hea, rv);
			chk8(rv, pat[7:0]);
			rd_reg(8'heb, rv);
			chk8(rv, sum_hi(pat));
			// level still high: a cleared flag must stay clear
			rd_reg(8'hea, rv);
			chk8(rv, 8'h00);
			rd_reg(8'heb, rv);
			chk8(rv, 8'h00);
			cycles(2);
			chk8({7'h00, irq}, 8'h00);
			@(posedge clk);
			chan_irq <= 14'h0000;
			cycles(2);
			rd_reg(8'hea, rv);
			chk8(rv, 8'h00);
		end
		for (int r = 0; r < 3; r++) begin
			@(posedge clk);
			chan_e1 <= (r == 0) ? 14'h3fff : 14'($random(seed));
			wr_reg(8'hf4, 8'hff);
			cycles(1);
			chk14(chan_arb, chan_e1);
			rd_reg(8'hf4, rv);
			chk8(rv, 8'h01);
			rd_reg(8'hf2, rv);
			chk8(rv, chan_e1[7:0]);
			rd_reg(8'hf3, rv);
			chk8(rv, {2'b00, chan_e1[13:8]});
			wr_reg(8'hf4, 8'hfe);
			cycles(1);
			chk14(chan_arb, 14'h0000);
		end
		// nibbles 14 and 15 are not channels, so no shaping write may show
		for (int ch = 0; ch < 16; ch++) begin
			idx = 3'($random(seed));
			rv = 8'($random(seed));
			wr_reg({ch[3:0], 1'b1, idx}, rv);
			chk8({7'h00, shape_wr}, {7'h00, ch < 14});
			if (ch < 14) begin
				chk8({4'h0, shape_ch}, {4'h0, ch[3:0]});
				chk8({5'h00, shape_idx}, {5'h00, idx});
				chk8(shape_data, rv);
			end
			wr_reg({ch[3:0], 1'b0, idx}, rv);
			chk8({7'h00, shape_wr}, 8'h00);
		end
		// new activity in the very cycle of the read: the flag survives the clear
		@(posedge clk);
		rd <= 1'b1;
		addr <= 8'heb;
		chan_irq <= 14'h2000;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk8(rdata, 8'h00);
		rd_reg(8'heb, rv);
		chk8(rv, 8'h20);
		// a second reset must wipe flags, enable and pulse modes
		wr_reg(8'hf0, 8'h41);
		wr_reg(8'hf4, 8'h01);
		@(posedge clk);
		chan_irq <= 14'h0041;
		cycles(2);
		chk8({7'h00, irq}, 8'h01);
		@(posedge clk);
		nrst <= 1'b0;
		chan_irq <= 14'h0000;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(8'hea, rv);
		chk8(rv, 8'h00);
		chk8({7'h00, irq}, 8'h00);
		rd_reg(8'hf4, rv);
		chk8(rv, 8'h00);
		chk14(chan_arb, 14'h0000);
		summarize();
	end
endmodule
`default_nettype wire
